// ---- core/ccw_pkg.sv ----
// shared types and constants for the call, clear and watchdog-clear executor
package ccw_pkg;

    localparam int CCW_PC_W = 10; // program counter width
    localparam int CCW_ADDR_W = 8; // data memory address width
    localparam int CCW_DATA_W = 8; // data memory word width
    localparam int CCW_BIT_W = 3; // bit index width within one word

    localparam logic [CCW_PC_W-1:0] CCW_PC_STEP = 10'h001; // next instruction
    localparam logic [CCW_DATA_W-1:0] CCW_BYTE_ZERO = 8'h00; // cleared byte
    localparam logic [CCW_DATA_W-1:0] CCW_BIT_ONE = 8'h01; // mask seed
    localparam logic CCW_FLAG_CLEAR = 1'b0; // cleared status flag
    localparam logic CCW_FLAG_RESET = 1'b0; // flag value after reset
    localparam logic CCW_PAIR_FIRST = 1'b0; // record code: first half last
    localparam logic CCW_PAIR_SECOND = 1'b1; // record code: second half last
    localparam logic [1:0] CCW_RST_SYNC_INIT = 2'h0; // reset synchroniser

    // instructions this block executes
    typedef enum logic [2:0] {
        CCW_OP_NONE = 3'h0,
        CCW_OP_CALL = 3'h1,
        CCW_OP_BYTE_ZERO = 3'h2,
        CCW_OP_BIT_ZERO = 3'h3,
        CCW_OP_WDT_SINGLE = 3'h4,
        CCW_OP_WDT_FIRST = 3'h5,
        CCW_OP_WDT_SECOND = 3'h6
    } ccw_op_type;

    // one decoded instruction from the decode stage
    typedef struct packed {
        logic valid;
        ccw_op_type op;
        logic [CCW_PC_W-1:0] target;
        logic [CCW_ADDR_W-1:0] addr;
        logic [CCW_BIT_W-1:0] bitsel;
    } ccw_instr_type;

    // data memory write request
    typedef struct packed {
        logic we;
        logic [CCW_ADDR_W-1:0] addr;
        logic [CCW_DATA_W-1:0] wdata;
    } ccw_mem_wr_type;

    // executor sequencing states, one-hot
    typedef enum logic [1:0] {
        CCW_ST_IDLE = 2'b01,
        CCW_ST_CALL_JUMP = 2'b10
    } ccw_state_type;

endpackage

// ---- core/ccw_bit_zero.sv ----
// word value with one selected bit forced low, others kept
`timescale 1ns/1ps
module ccw_bit_zero
    import ccw_pkg::*;
(
    input wire logic [CCW_DATA_W-1:0] i_word,
    input wire logic [CCW_BIT_W-1:0] i_bitsel,
    output logic [CCW_DATA_W-1:0] o_word
);

    // one-hot mask of the selected bit position
    function automatic logic [CCW_DATA_W-1:0] bit_mask(
        input logic [CCW_BIT_W-1:0] sel
    );
        bit_mask = CCW_BIT_ONE << sel;
    endfunction

    // clear only the chosen bit, keep the rest
    assign o_word = i_word & ~bit_mask(i_bitsel);

endmodule

// ---- core/ccw_exec.sv ----
// executor for call, byte/bit clear and the watchdog-clear instructions
`timescale 1ns/1ps
module ccw_exec
    import ccw_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire ccw_instr_type i_instr,
    output logic o_ready,
    input wire logic [CCW_PC_W-1:0] i_pc,
    output logic o_stack_push,
    output logic [CCW_PC_W-1:0] o_stack_data,
    output logic o_pc_load,
    output logic [CCW_PC_W-1:0] o_pc_target,
    input wire logic [CCW_DATA_W-1:0] i_mem_rdata,
    output ccw_mem_wr_type o_mem_wr,
    output logic o_watchdog_restart,
    input wire logic i_timeout_set,
    input wire logic i_powerdown_set,
    output logic o_timeout_flag,
    output logic o_powerdown_flag
);

    logic [1:0] rst_sync; // reset release synchroniser
    logic rst_n; // synchronised reset, active low
    ccw_state_type state; // sequencing state
    ccw_state_type next_state; // state for the next edge
    logic [CCW_PC_W-1:0] call_target; // target held for the jump cycle
    logic take; // instruction accepted this cycle
    logic pair_last; // which paired clear ran last
    logic pair_armed; // a paired clear has run since reset
    logic pair_hit; // paired clear that alternates with the last one
    logic wdt_clear; // any watchdog clear that takes effect
    logic [CCW_DATA_W-1:0] bit_cleared; // read word with one bit cleared

    // release reset through two flops, assert without the clock
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync <= CCW_RST_SYNC_INIT;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // new work is taken only in the idle state
    assign o_ready = (state == CCW_ST_IDLE);
    assign take = i_instr.valid && o_ready;

    // paired clear counts only once armed and when it differs from the recorded one
    always_comb begin
        pair_hit = 1'b0;
        if (take && pair_armed) begin
            if (i_instr.op == CCW_OP_WDT_FIRST) begin
                pair_hit = (pair_last == CCW_PAIR_SECOND);
            end else if (i_instr.op == CCW_OP_WDT_SECOND) begin
                pair_hit = (pair_last == CCW_PAIR_FIRST);
            end
        end
    end

    // single clear always acts, paired ones only on alternation
    assign wdt_clear = (take && i_instr.op == CCW_OP_WDT_SINGLE)
        || pair_hit;

    // next sequencing state
    always_comb begin
        next_state = state;
        unique case (state)
            CCW_ST_IDLE: begin
                if (take && i_instr.op == CCW_OP_CALL) begin
                    next_state = CCW_ST_CALL_JUMP; // second cycle
                end
            end
            CCW_ST_CALL_JUMP: begin
                next_state = CCW_ST_IDLE;
            end
            default: begin
                next_state = CCW_ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= CCW_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // call: push the return address in the first cycle
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_stack_push <= 1'b0;
            o_stack_data <= '0;
            call_target <= '0;
        end else begin
            o_stack_push <= take && i_instr.op == CCW_OP_CALL;
            if (take && i_instr.op == CCW_OP_CALL) begin
                o_stack_data <= i_pc + CCW_PC_STEP;
                call_target <= i_instr.target;
            end
        end
    end

    // call: load the target in the second cycle, no condition
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_pc_load <= 1'b0;
            o_pc_target <= '0;
        end else begin
            o_pc_load <= (state == CCW_ST_CALL_JUMP);
            if (state == CCW_ST_CALL_JUMP) begin
                o_pc_target <= call_target;
            end
        end
    end

    // bit clear works on the word read at the given address
    ccw_bit_zero u_bit_zero (
        .i_word(i_mem_rdata),
        .i_bitsel(i_instr.bitsel),
        .o_word(bit_cleared)
    );

    // data memory writes for byte and bit clear
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_mem_wr <= '0;
        end else begin
            o_mem_wr.we <= take && (i_instr.op == CCW_OP_BYTE_ZERO
                || i_instr.op == CCW_OP_BIT_ZERO);
            if (take && i_instr.op == CCW_OP_BYTE_ZERO) begin
                o_mem_wr.addr <= i_instr.addr;
                o_mem_wr.wdata <= CCW_BYTE_ZERO;
            end else if (take && i_instr.op == CCW_OP_BIT_ZERO) begin
                o_mem_wr.addr <= i_instr.addr;
                o_mem_wr.wdata <= bit_cleared;
            end
        end
    end

    // record of the last paired clear, cleared by reset
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            pair_last <= CCW_PAIR_FIRST;
            pair_armed <= 1'b0;
        end else if (take && i_instr.op == CCW_OP_WDT_FIRST) begin
            pair_last <= CCW_PAIR_FIRST;
            pair_armed <= 1'b1;
        end else if (take && i_instr.op == CCW_OP_WDT_SECOND) begin
            pair_last <= CCW_PAIR_SECOND;
            pair_armed <= 1'b1;
        end
    end

    // watchdog counter restart pulse
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_watchdog_restart <= 1'b0;
        end else begin
            o_watchdog_restart <= wdt_clear;
        end
    end

    // status flags: a set in the clearing cycle wins over the clear
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_timeout_flag <= CCW_FLAG_RESET;
            o_powerdown_flag <= CCW_FLAG_RESET;
        end else begin
            if (i_timeout_set) begin
                o_timeout_flag <= 1'b1;
            end else if (wdt_clear) begin
                o_timeout_flag <= CCW_FLAG_CLEAR;
            end
            if (i_powerdown_set) begin
                o_powerdown_flag <= 1'b1;
            end else if (wdt_clear) begin
                o_powerdown_flag <= CCW_FLAG_CLEAR;
            end
        end
    end

    // checks on the behaviour above
    call_push_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        take && i_instr.op == CCW_OP_CALL |=>
            o_stack_push && o_stack_data == $past(i_pc) + CCW_PC_STEP)
        else $error("call did not push the next address");

    call_jump_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        take && i_instr.op == CCW_OP_CALL |=> ##1
            o_pc_load && o_pc_target == $past(i_instr.target, 2))
        else $error("call did not load its target");

    call_cycles_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        take && i_instr.op == CCW_OP_CALL |=> !o_ready ##1 o_ready)
        else $error("call did not take two cycles");

    byte_zero_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        take && i_instr.op == CCW_OP_BYTE_ZERO |=>
            o_mem_wr.we && o_mem_wr.wdata == CCW_BYTE_ZERO
            && o_mem_wr.addr == $past(i_instr.addr) && !o_watchdog_restart)
        else $error("byte clear wrote a wrong value");

    bit_zero_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        take && i_instr.op == CCW_OP_BIT_ZERO |=>
            o_mem_wr.we && o_mem_wr.wdata[$past(i_instr.bitsel)] == 1'b0
            && (o_mem_wr.wdata | (CCW_BIT_ONE << $past(i_instr.bitsel)))
            == ($past(i_mem_rdata) | (CCW_BIT_ONE << $past(i_instr.bitsel))))
        else $error("bit clear disturbed other bits");

    single_clear_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        take && i_instr.op == CCW_OP_WDT_SINGLE && !i_timeout_set
            && !i_powerdown_set |=>
            o_watchdog_restart && !o_timeout_flag && !o_powerdown_flag)
        else $error("single watchdog clear had no effect");

    pair_take_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        take && i_instr.op == CCW_OP_WDT_FIRST ##1
            take && i_instr.op == CCW_OP_WDT_SECOND |=> o_watchdog_restart)
        else $error("alternated paired clear had no effect");

    pair_repeat_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        take && i_instr.op == CCW_OP_WDT_FIRST ##1
            take && i_instr.op == CCW_OP_WDT_FIRST |=>
            !o_watchdog_restart && $stable(o_timeout_flag | i_timeout_set)
            || i_timeout_set)
        else $error("repeated first paired clear acted");

    pair_sym_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        take && i_instr.op == CCW_OP_WDT_SECOND ##1
            take && i_instr.op == CCW_OP_WDT_SECOND |=> !o_watchdog_restart)
        else $error("repeated second paired clear acted");

    flag_cause_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        $fell(o_timeout_flag) || $fell(o_powerdown_flag) |->
            o_watchdog_restart)
        else $error("status flag cleared without a watchdog clear");

    pair_first_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        take && i_instr.op == CCW_OP_WDT_FIRST && !pair_armed |=>
            !o_watchdog_restart && pair_armed)
        else $error("first paired clear after reset acted");

endmodule

// ---- tb/ccw_exec_tb_top.sv ----
// self-checking bench for the call, clear and watchdog-clear executor
`timescale 1ns/1ps
module ccw_exec_tb_top;
    import ccw_pkg::*;

    logic i_mclk = 1'b0; // core clock, 4 ns period
    logic i_arst_n = 1'b0; // async reset, active low
    ccw_instr_type i_instr = '0; // decoded instruction to the executor
    logic [CCW_PC_W-1:0] i_pc = 10'h000; // current program counter
    logic [CCW_DATA_W-1:0] i_mem_rdata = 8'h00; // addressed memory word
    logic i_timeout_set = 1'b0; // sets the time-out flag
    logic i_powerdown_set = 1'b0; // sets the power-down flag
    logic o_ready, o_stack_push, o_pc_load, o_watchdog_restart;
    logic o_timeout_flag, o_powerdown_flag;
    logic [CCW_PC_W-1:0] o_stack_data, o_pc_target;
    ccw_mem_wr_type o_mem_wr;
    int n_errors = 0; // mismatches seen
    int num_checks = 0; // comparisons made

    // free-running clock
    always #2 i_mclk = ~i_mclk;

    ccw_exec dut (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_instr(i_instr),
        .o_ready(o_ready), .i_pc(i_pc), .o_stack_push(o_stack_push),
        .o_stack_data(o_stack_data), .o_pc_load(o_pc_load),
        .o_pc_target(o_pc_target), .i_mem_rdata(i_mem_rdata),
        .o_mem_wr(o_mem_wr), .o_watchdog_restart(o_watchdog_restart),
        .i_timeout_set(i_timeout_set), .i_powerdown_set(i_powerdown_set),
        .o_timeout_flag(o_timeout_flag), .o_powerdown_flag(o_powerdown_flag)
    );

    // compare one flag or pulse
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // compare one data value, zero-extended to 16 bits
    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // prints counts and verdict, then stops
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // builds a valid instruction
    function automatic ccw_instr_type mk(input ccw_op_type op,
        input logic [CCW_PC_W-1:0] t, input logic [CCW_ADDR_W-1:0] a,
        input logic [CCW_BIT_W-1:0] b);
        mk = '{1'b1, op, t, a, b};
    endfunction

    // hold reset 8 cycles, then wait out the synchroniser
    task automatic do_reset();
        @(posedge i_mclk);
        i_arst_n <= 1'b0;
        repeat (8) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
    endtask

    // one-cycle request; returns just after the answer edge
    task automatic send(input ccw_instr_type x);
        @(posedge i_mclk);
        i_instr <= x;
        @(posedge i_mclk);
        i_instr <= '0;
        #1;
    endtask

    // raise both status flags and confirm they are up
    task automatic set_flags();
        @(posedge i_mclk);
        i_timeout_set <= 1'b1;
        i_powerdown_set <= 1'b1;
        @(posedge i_mclk);
        i_timeout_set <= 1'b0;
        i_powerdown_set <= 1'b0;
        #1;
        chk_bit(o_timeout_flag & o_powerdown_flag, 1'b1);
    endtask

    // one watchdog-clear op with flags up; act says whether it takes effect
    task automatic wd(input ccw_op_type op, input logic act);
        set_flags();
        send(mk(op, 10'h000, 8'h00, 3'h0));
        chk_bit(o_watchdog_restart, act);
        chk_bit(o_timeout_flag, ~act);
        chk_bit(o_powerdown_flag, ~act);
    endtask

    // paired clears: fresh record, repeats, alternation, reset of record
    task automatic t_pair();
        wd(CCW_OP_WDT_FIRST, 1'b0);
        wd(CCW_OP_WDT_FIRST, 1'b0);
        wd(CCW_OP_WDT_SECOND, 1'b1);
        wd(CCW_OP_WDT_SECOND, 1'b0);
        wd(CCW_OP_WDT_FIRST, 1'b1);
        wd(CCW_OP_WDT_SECOND, 1'b1);
        wd(CCW_OP_WDT_FIRST, 1'b1);
        do_reset();
        wd(CCW_OP_WDT_SECOND, 1'b0);
        $display("test pair done");
    endtask

    // call at the top of the address range; request in dead cycle refused
    task automatic t_call();
        @(posedge i_mclk);
        i_pc <= 10'h3FF;
        i_instr <= mk(CCW_OP_CALL, 10'h155, 8'h00, 3'h0);
        @(posedge i_mclk);
        i_instr <= mk(CCW_OP_BYTE_ZERO, 10'h000, 8'h3C, 3'h0);
        #1;
        chk_bit(o_stack_push, 1'b1);
        chk_vec(16'(o_stack_data), 16'h0000);
        chk_bit(o_pc_load, 1'b0);
        chk_bit(o_ready, 1'b0);
        @(posedge i_mclk);
        i_instr <= '0;
        #1;
        chk_bit(o_pc_load, 1'b1);
        chk_vec(16'(o_pc_target), 16'h0155);
        chk_bit(o_stack_push, 1'b0);
        chk_bit(o_ready, 1'b1);
        chk_bit(o_mem_wr.we, 1'b0);
        @(posedge i_mclk);
        #1;
        chk_bit(o_pc_load, 1'b0);
        chk_bit(o_mem_wr.we, 1'b0);
        $display("test call done");
    endtask

    // byte clear with flags up: zero written, flags kept
    task automatic t_byte();
        set_flags();
        @(posedge i_mclk);
        i_mem_rdata <= 8'hFF;
        send(mk(CCW_OP_BYTE_ZERO, 10'h000, 8'hA5, 3'h0));
        chk_bit(o_mem_wr.we, 1'b1);
        chk_vec(16'(o_mem_wr.addr), 16'h00A5);
        chk_vec(16'(o_mem_wr.wdata), 16'h0000);
        chk_bit(o_timeout_flag & o_powerdown_flag, 1'b1);
        @(posedge i_mclk);
        #1;
        chk_bit(o_mem_wr.we, 1'b0);
        $display("test byte clear done");
    endtask

    // bit clear of every position, then on a mixed word
    task automatic t_bit();
        logic [CCW_DATA_W-1:0] e;
        for (int i = 0; i < 9; i++) begin
            @(posedge i_mclk);
            i_mem_rdata <= (i < 8) ? 8'hFF : 8'h5A;
            e = (i < 8) ? ~(8'h01 << i) : 8'h58;
            // the mixed word clears bit 1, which is set in it
            send(mk(CCW_OP_BIT_ZERO, 10'h000, 8'h0F,
                (i < 8) ? 3'(i) : 3'h1));
            chk_bit(o_mem_wr.we, 1'b1);
            chk_vec(16'(o_mem_wr.wdata), 16'(e));
            chk_bit(o_timeout_flag & o_powerdown_flag, 1'b1);
        end
        $display("test bit clear done");
    endtask

    // single watchdog clear acts every time
    task automatic t_single();
        wd(CCW_OP_WDT_SINGLE, 1'b1);
        wd(CCW_OP_WDT_SINGLE, 1'b1);
        $display("test single clear done");
    endtask

    // paired clears back to back; the record holds the second half last
    task automatic t_burst();
        set_flags();
        @(posedge i_mclk);
        i_instr <= mk(CCW_OP_WDT_FIRST, 10'h000, 8'h00, 3'h0);
        @(posedge i_mclk);
        i_instr <= mk(CCW_OP_WDT_FIRST, 10'h000, 8'h00, 3'h0);
        #1;
        chk_bit(o_watchdog_restart, 1'b1);
        chk_bit(o_timeout_flag | o_powerdown_flag, 1'b0);
        @(posedge i_mclk);
        i_instr <= mk(CCW_OP_WDT_SECOND, 10'h000, 8'h00, 3'h0);
        #1;
        chk_bit(o_watchdog_restart, 1'b0);
        @(posedge i_mclk);
        i_instr <= mk(CCW_OP_WDT_SECOND, 10'h000, 8'h00, 3'h0);
        #1;
        chk_bit(o_watchdog_restart, 1'b1);
        @(posedge i_mclk);
        i_instr <= '0;
        #1;
        chk_bit(o_watchdog_restart, 1'b0);
        $display("test paired burst done");
    endtask

    // a flag set in the clearing cycle wins, the other flag still clears
    task automatic t_race();
        set_flags();
        @(posedge i_mclk);
        i_instr <= mk(CCW_OP_WDT_SINGLE, 10'h000, 8'h00, 3'h0);
        i_timeout_set <= 1'b1;
        @(posedge i_mclk);
        i_timeout_set <= 1'b0;
        i_powerdown_set <= 1'b1;
        #1;
        chk_bit(o_watchdog_restart, 1'b1);
        chk_bit(o_timeout_flag, 1'b1);
        chk_bit(o_powerdown_flag, 1'b0);
        @(posedge i_mclk);
        i_instr <= '0;
        i_powerdown_set <= 1'b0;
        #1;
        chk_bit(o_watchdog_restart, 1'b1);
        chk_bit(o_timeout_flag, 1'b0);
        chk_bit(o_powerdown_flag, 1'b1);
        $display("test set against clear done");
    endtask

    // main sequence
    initial begin
        do_reset();
        t_pair();
        t_call();
        t_byte();
        t_bit();
        t_single();
        t_burst();
        t_race();
        complete_run();
    end

    // hang guard, far beyond the 113 cycles the tests need
    initial begin
        repeat (5000) @(posedge i_mclk);
        n_errors++;
        complete_run();
    end
endmodule
